// [src/mdd_pkg.sv]
// Purpose: constants and types for the message destination dispatch block
// Assumes: one 100 MHz clock, APB register access, 32-bit data
// Notes:   record word layouts follow the packed structs
//
// Summary of operation
// - transmit requests send the text out the serial port
// - item codes become live date, time, timer or data values
// - control characters pass through unchanged
// - no terminator appended; the text must end with it
// - assembled string at most 255 bytes
// - combined records send their string first
// - then the queue entry is made and display decided
// - command records execute when requested
// - commands accepted from every request source
// - command number and data select the action
// - commands: default load, cancel entry, show entry
// - commands change configuration on-line
// - a command sends the configuration as ASCII
// - time-out runs only while displayed
// - displaced message saves its remaining count
// - returning message resumes from saved count
// - expired message is cancelled
// - expired chained message requests the next member
// - time-out ranges: 10-1270 ms, 0-127 s, 1-87 min
// - disabled time-out never expires
// - shown only if priority is equal or higher
package mdd_pkg;

   localparam logic [7:0]  ADDR_CTRL  = 8'h00;
   localparam logic [7:0]  ADDR_REC_A = 8'h04;
   localparam logic [7:0]  ADDR_REC_B = 8'h08;
   localparam logic [7:0]  ADDR_TXT   = 8'h0C;
   localparam logic [7:0]  ADDR_CFG   = 8'h10;
   localparam logic [7:0]  ADDR_SHOW  = 8'h14;
   localparam int          CTRL_GO    = 0;
   localparam int          CTRL_CLR   = 1;
   localparam int          CFG_QON    = 8;
   localparam logic [8:0]  CFG_RESET  = 9'h10D;
   localparam logic [7:0]  MAX_LEN    = 8'hFF;
   localparam logic [5:0]  ITEM_TAG   = 6'h20;
   localparam logic [7:0]  EOL_CHAR   = 8'h0D;

   localparam int          TICK_MS    = 10;
   localparam int          CLK_MHZ    = 100;
   localparam int          TICK_CYC   = TICK_MS * 1000 * CLK_MHZ;
   localparam logic [18:0] SEC_TICKS  = 19'h00064;
   localparam logic [18:0] MIN_TICKS  = 19'h01770;

   localparam logic [1:0]  TMO_OFF    = 2'h0;
   localparam logic [1:0]  TMO_MS     = 2'h1;
   localparam logic [1:0]  TMO_SEC    = 2'h2;
   localparam logic [1:0]  TMO_MIN    = 2'h3;

   localparam logic [7:0]  DUMP_CONFIG_CMD         = 8'h01;
   localparam logic [7:0]  SET_CONFIG_CMD          = 8'h03;
   localparam logic [7:0]  LOAD_DEFAULT_CONFIG_CMD = 8'h11;
   localparam logic [7:0]  CANCEL_ENTRY_CMD        = 8'h14;
   localparam logic [7:0]  SHOW_ENTRY_CMD          = 8'h15;

   typedef enum logic [2:0] {
      DEST_SHOW           = 3'h0,
      DEST_SLAVE          = 3'h1,
      DEST_XMIT           = 3'h2,
      DEST_SHOW_AND_SLAVE = 3'h3,
      DEST_SHOW_XMIT      = 3'h4,
      DEST_CMD            = 3'h5
   } mdd_dest_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_XMIT, ST_HEX, ST_EOL, ST_PLACE, ST_CMD
   } mdd_state_type;

   typedef struct packed {
      logic [14:0]  cdata;
      logic [7:0]   cmd;
      logic [6:0]   tval;
      logic [1:0]   trng;
      logic [2:0]   pad;
      logic [7:0]   next;
      logic         chain;
      logic         queue;
      logic [7:0]   pri;
      mdd_dest_type dest;
      logic [7:0]   msg;
   } mdd_rec_type;

   typedef struct packed {
      logic [7:0]  msg;
      logic [7:0]  pri;
      logic        chain;
      logic [7:0]  next;
      logic        tmo_on;
      logic [18:0] remain;
   } mdd_entry_type;

endpackage

// [src/mdd_dispatch.sv]
// Purpose: routes a requested message record to serial send, display
//          placement or command execution, and runs its display time-out
// Assumes: message store and queue live outside; text staged over APB
// Notes:   APB answers with zero wait states; one request at a time
`timescale 1ns/1ps
`default_nettype none

module mdd_dispatch #(
   parameter int TICK_CYCLES = mdd_pkg::TICK_CYC
) (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 req_valid,
   input  wire mdd_pkg::mdd_rec_type req_rec,
   output logic                      req_ready,
   input  wire logic [3:0][31:0]     live_items,
   output logic [7:0]                tx_data,
   output logic                      tx_valid,
   input  wire logic                 tx_ready,
   output logic                      q_push_valid,
   output mdd_pkg::mdd_entry_type    q_push_entry,
   input  wire logic                 q_ret_valid,
   input  wire mdd_pkg::mdd_entry_type q_ret_entry,
   output logic                      q_ret_ready,
   output logic                      cancel_valid,
   output logic [7:0]                cancel_msg,
   output logic                      fetch_valid,
   output logic [7:0]                fetch_msg,
   output logic                      shown_valid,
   output logic [7:0]                shown_msg
);

   mdd_pkg::mdd_state_type state_q, state_d;
   mdd_pkg::mdd_rec_type   rec_q;
   mdd_pkg::mdd_entry_type shown_q, push_q;

   logic [7:0]  text_q [0:255];
   logic [7:0]  tlen_q, ptr_q, olen_q, tx_data_q, cancel_msg_q, fetch_msg_q;
   logic [31:0] hex_q, rec_a_q, rec_b_q, div_q, prdata_q;
   logic [8:0]  cfg_q;
   logic [2:0]  nib_q;
   logic        len_err_q, dump_q, shown_v_q, tick_pend_q, tx_valid_q;
   logic        push_v_q, cancel_v_q, fetch_v_q, pready_q, pslverr_q;
   logic        req_ready_q, q_ret_ready_q;

   // time-out setting to a count of 10 ms ticks
   function automatic logic [18:0] tmo_ticks(input logic [1:0] rng,
                                             input logic [6:0] val);
      logic [18:0] v;
      v = {12'h000, val};
      case (rng)
         mdd_pkg::TMO_MS:  tmo_ticks = v;
         mdd_pkg::TMO_SEC: tmo_ticks = 19'(v * mdd_pkg::SEC_TICKS);
         mdd_pkg::TMO_MIN: tmo_ticks = 19'(v * mdd_pkg::MIN_TICKS);
         default:          tmo_ticks = 19'h00000;
      endcase
   endfunction

   // one ASCII hex digit, upper case
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? 8'({4'h3, n})
                            : 8'(8'h37 + {4'h0, n});
   endfunction

   // APB decode
   wire apb_setup = psel & ~penable;
   wire hit_ctrl  = (paddr == mdd_pkg::ADDR_CTRL);
   wire hit_rec_a = (paddr == mdd_pkg::ADDR_REC_A);
   wire hit_rec_b = (paddr == mdd_pkg::ADDR_REC_B);
   wire hit_txt   = (paddr == mdd_pkg::ADDR_TXT);
   wire hit_cfg   = (paddr == mdd_pkg::ADDR_CFG);
   wire hit_show  = (paddr == mdd_pkg::ADDR_SHOW);
   wire hit_any   = hit_ctrl | hit_rec_a | hit_rec_b | hit_txt
                  | hit_cfg | hit_show;
   wire apb_wr    = psel & penable & pwrite & pready_q & ~pslverr_q;

   // request sources: port first, APB go only when the port is quiet
   wire idle      = (state_q == mdd_pkg::ST_IDLE);
   wire req_take  = req_valid & req_ready_q;
   wire go_apb    = apb_wr & hit_ctrl & pwdata[mdd_pkg::CTRL_GO]
                  & idle & ~req_take;
   wire start     = req_take | go_apb;
   wire [63:0] apb_rec_w = {rec_b_q, rec_a_q};
   wire mdd_pkg::mdd_rec_type new_rec = req_take ? req_rec
                  : mdd_pkg::mdd_rec_type'(apb_rec_w);

   // destination classes
   wire new_comb  = (new_rec.dest == mdd_pkg::DEST_SHOW_AND_SLAVE)
                  | (new_rec.dest == mdd_pkg::DEST_SHOW_XMIT);
   wire new_tx    = new_comb | (new_rec.dest == mdd_pkg::DEST_XMIT)
                  | (new_rec.dest == mdd_pkg::DEST_SLAVE);
   wire new_cmd   = (new_rec.dest == mdd_pkg::DEST_CMD);
   wire rec_comb  = (rec_q.dest == mdd_pkg::DEST_SHOW_AND_SLAVE)
                  | (rec_q.dest == mdd_pkg::DEST_SHOW_XMIT);

   // string assembly
   wire       tx_free  = ~tx_valid_q | tx_ready;
   wire [7:0] cur_b    = text_q[ptr_q];
   wire       is_item  = (cur_b[7:2] == mdd_pkg::ITEM_TAG);
   wire       at_end   = (ptr_q == tlen_q);
   wire       len_full = (olen_q == mdd_pkg::MAX_LEN);
   wire mdd_pkg::mdd_state_type fin_state = rec_comb ? mdd_pkg::ST_PLACE
                                                     : mdd_pkg::ST_IDLE;

   // time-out tick is held pending while a placement or command runs,
   // so expiry never collides with their cancel or fetch pulses
   wire tick_use  = tick_pend_q & (state_q != mdd_pkg::ST_PLACE)
                  & (state_q != mdd_pkg::ST_CMD);
   wire expire    = tick_use & shown_v_q & shown_q.tmo_on
                  & (shown_q.remain <= 19'h00001);
   wire live      = shown_v_q & ~expire;
   wire wins      = ~live | (rec_q.pri <= shown_q.pri);
   wire q_ret_take = q_ret_valid & q_ret_ready_q;
   wire cmd_run   = (state_q == mdd_pkg::ST_CMD);
   wire [8:0] cdata9 = rec_q.cdata[8:0];

   // entry from the placed record
   wire mdd_pkg::mdd_entry_type rec_entry = '{
      msg:    rec_q.msg,
      pri:    rec_q.pri,
      chain:  rec_q.chain,
      next:   rec_q.next,
      tmo_on: (rec_q.trng != mdd_pkg::TMO_OFF),
      remain: tmo_ticks(rec_q.trng, rec_q.tval)
   };

   // next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         mdd_pkg::ST_IDLE:
            if (start)
               state_d = new_cmd ? mdd_pkg::ST_CMD
                       : new_tx  ? mdd_pkg::ST_XMIT
                       : mdd_pkg::ST_PLACE;
         mdd_pkg::ST_XMIT:
            if (tx_free & (at_end | len_full))
               state_d = fin_state;
            else if (tx_free & is_item)
               state_d = mdd_pkg::ST_HEX;
         mdd_pkg::ST_HEX:
            if (tx_free & len_full)
               state_d = fin_state;
            else if (tx_free & (nib_q == 3'h0))
               state_d = dump_q ? mdd_pkg::ST_EOL : mdd_pkg::ST_XMIT;
         mdd_pkg::ST_EOL:
            if (tx_free & ~dump_q)
               state_d = mdd_pkg::ST_IDLE;
         mdd_pkg::ST_CMD:
            state_d = (rec_q.cmd == mdd_pkg::DUMP_CONFIG_CMD)
                    ? mdd_pkg::ST_HEX : mdd_pkg::ST_IDLE;
         mdd_pkg::ST_PLACE:
            state_d = mdd_pkg::ST_IDLE;
         default:
            state_d = mdd_pkg::ST_IDLE;
      endcase
   end

   // sequencer: record capture and serial byte production
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q    <= mdd_pkg::ST_IDLE;
         rec_q      <= '0;
         ptr_q      <= 8'h00;
         olen_q     <= 8'h00;
         len_err_q  <= 1'b0;
         hex_q      <= 32'h00000000;
         nib_q      <= 3'h0;
         dump_q     <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_data_q  <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         if (tx_ready)
            tx_valid_q <= 1'b0;
         case (state_q)
            mdd_pkg::ST_IDLE:
               if (start)
               begin
                  rec_q     <= new_rec;
                  ptr_q     <= 8'h00;
                  olen_q    <= 8'h00;
                  len_err_q <= 1'b0;
                  dump_q    <= 1'b0;
               end
            mdd_pkg::ST_XMIT:
               if (tx_free)
               begin
                  if (at_end | len_full)
                     len_err_q <= len_full & ~at_end;
                  else if (is_item)
                  begin
                     hex_q <= live_items[cur_b[1:0]];
                     nib_q <= 3'h7;
                  end
                  else
                  begin
                     tx_data_q  <= cur_b;
                     tx_valid_q <= 1'b1;
                     ptr_q      <= ptr_q + 8'h01;
                     olen_q     <= olen_q + 8'h01;
                  end
               end
            mdd_pkg::ST_HEX:
               if (tx_free)
               begin
                  if (len_full)
                     len_err_q <= 1'b1;
                  else
                  begin
                     tx_data_q  <= hex_char(hex_q[31:28]);
                     tx_valid_q <= 1'b1;
                     hex_q      <= {hex_q[27:0], 4'h0};
                     nib_q      <= nib_q - 3'h1;
                     olen_q     <= olen_q + 8'h01;
                     if (nib_q == 3'h0)
                        ptr_q <= ptr_q + 8'h01;
                  end
               end
            // stay until the end byte is taken, so idle means all sent
            mdd_pkg::ST_EOL:
               if (tx_free & dump_q)
               begin
                  tx_data_q  <= mdd_pkg::EOL_CHAR;
                  tx_valid_q <= 1'b1;
                  dump_q     <= 1'b0;
               end
            mdd_pkg::ST_CMD:
               if (rec_q.cmd == mdd_pkg::DUMP_CONFIG_CMD)
               begin
                  hex_q  <= {23'h000000, cfg_q};
                  nib_q  <= 3'h7;
                  dump_q <= 1'b1;
               end
            default:
               ;
         endcase
      end
   end

   // 10 ms tick divider; a pending tick waits for a free cycle
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         div_q       <= 32'h00000000;
         tick_pend_q <= 1'b0;
      end
      else if (div_q == 32'(TICK_CYCLES - 1))
      begin
         div_q       <= 32'h00000000;
         tick_pend_q <= 1'b1;
      end
      else
      begin
         div_q <= div_q + 32'h00000001;
         if (tick_use)
            tick_pend_q <= 1'b0;
      end
   end

   // display slot, queue hand-off, commands and configuration
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         shown_q      <= '0;
         shown_v_q    <= 1'b0;
         push_q       <= '0;
         push_v_q     <= 1'b0;
         cancel_v_q   <= 1'b0;
         cancel_msg_q <= 8'h00;
         fetch_v_q    <= 1'b0;
         fetch_msg_q  <= 8'h00;
         cfg_q        <= mdd_pkg::CFG_RESET;
      end
      else
      begin
         push_v_q   <= 1'b0;
         cancel_v_q <= 1'b0;
         fetch_v_q  <= 1'b0;
         if (apb_wr & hit_cfg)
            cfg_q <= pwdata[8:0];
         // count down only the displayed message, never when disabled
         if (tick_use & shown_v_q & shown_q.tmo_on)
         begin
            if (expire)
            begin
               shown_v_q    <= 1'b0;
               cancel_v_q   <= 1'b1;
               cancel_msg_q <= shown_q.msg;
               fetch_v_q    <= shown_q.chain;
               fetch_msg_q  <= shown_q.next;
            end
            else
               shown_q.remain <= shown_q.remain - 19'h00001;
         end
         if (q_ret_take)
         begin
            shown_q   <= q_ret_entry;
            shown_v_q <= 1'b1;
         end
         if (state_q == mdd_pkg::ST_PLACE)
         begin
            if (wins)
            begin
               shown_q   <= rec_entry;
               shown_v_q <= 1'b1;
               push_q    <= shown_q;
               push_v_q  <= live;
            end
            else if (rec_q.queue & cfg_q[mdd_pkg::CFG_QON])
            begin
               push_q   <= rec_entry;
               push_v_q <= 1'b1;
            end
         end
         if (cmd_run)
         begin
            case (rec_q.cmd)
               mdd_pkg::LOAD_DEFAULT_CONFIG_CMD:
                  cfg_q <= mdd_pkg::CFG_RESET;
               mdd_pkg::SET_CONFIG_CMD:
                  cfg_q <= cdata9;
               mdd_pkg::CANCEL_ENTRY_CMD:
               begin
                  cancel_v_q   <= 1'b1;
                  cancel_msg_q <= rec_q.cdata[7:0];
                  if (shown_v_q & (shown_q.msg == rec_q.cdata[7:0]))
                     shown_v_q <= 1'b0;
               end
               mdd_pkg::SHOW_ENTRY_CMD:
               begin
                  fetch_v_q   <= 1'b1;
                  fetch_msg_q <= rec_q.cdata[7:0];
               end
               default:
                  ;
            endcase
         end
      end
   end

   // staged message text; appends refused while a string is sent
   always_ff @(posedge mclk)
   begin
      if (apb_wr & hit_txt & idle & (tlen_q != mdd_pkg::MAX_LEN))
         text_q[tlen_q] <= pwdata[7:0];
   end

   // read mux
   wire [31:0] status_w = {29'h00000000, len_err_q, shown_v_q, ~idle};
   wire [31:0] show_w   = {5'h00, shown_q.msg, shown_q.remain};
   wire [31:0] rd_w     = hit_ctrl  ? status_w
                        : hit_rec_a ? rec_a_q
                        : hit_rec_b ? rec_b_q
                        : hit_txt   ? {24'h000000, tlen_q}
                        : hit_cfg   ? {23'h000000, cfg_q}
                        : hit_show  ? show_w
                        : 32'h00000000;

   // APB slave: zero wait states
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         prdata_q      <= 32'h00000000;
         pready_q      <= 1'b0;
         pslverr_q     <= 1'b0;
         rec_a_q       <= 32'h00000000;
         rec_b_q       <= 32'h00000000;
         tlen_q        <= 8'h00;
         req_ready_q   <= 1'b0;
         q_ret_ready_q <= 1'b0;
      end
      else
      begin
         pready_q  <= apb_setup;
         pslverr_q <= apb_setup & ~hit_any;
         if (apb_setup)
            prdata_q <= rd_w;
         if (apb_wr & hit_rec_a)
            rec_a_q <= pwdata;
         if (apb_wr & hit_rec_b)
            rec_b_q <= pwdata;
         if (apb_wr & hit_ctrl & pwdata[mdd_pkg::CTRL_CLR] & idle)
            tlen_q <= 8'h00;
         else if (apb_wr & hit_txt & idle
                  & (tlen_q != mdd_pkg::MAX_LEN))
            tlen_q <= tlen_q + 8'h01;
         req_ready_q   <= (state_d == mdd_pkg::ST_IDLE);
         // queue return only into an empty display while quiet
         q_ret_ready_q <= idle & (state_d == mdd_pkg::ST_IDLE)
                        & ~shown_v_q & ~q_ret_take;
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign req_ready    = req_ready_q;
   assign tx_data      = tx_data_q;
   assign tx_valid     = tx_valid_q;
   assign q_push_valid = push_v_q;
   assign q_push_entry = push_q;
   assign q_ret_ready  = q_ret_ready_q;
   assign cancel_valid = cancel_v_q;
   assign cancel_msg   = cancel_msg_q;
   assign fetch_valid  = fetch_v_q;
   assign fetch_msg    = fetch_msg_q;
   assign shown_valid  = shown_v_q;
   assign shown_msg    = shown_q.msg;

endmodule

`default_nettype wire

// [sim/mdd_serial_rx.sv]
// Purpose: serial receiver model on the far side of the byte stream
// Assumes: valid/ready handshake, one byte taken per handshake
// Notes:   slow mode grants every other cycle so bytes must be held
`timescale 1ns/1ps
`default_nettype none
module mdd_serial_rx (
   input  wire logic       mclk,
   input  wire logic       slow,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready
);
   logic [7:0] rx_q [0:15];
   int         n_q = 0;
   logic       ph_q = 1'b0;
   // ready toggles in slow mode to stress the sender's hold
   assign tx_ready = !slow | ph_q;
   // store each taken byte; ring of 16 is enough per test
   always_ff @(posedge mclk)
   begin
      ph_q <= !ph_q;
      if (tx_valid && tx_ready)
      begin
         rx_q[n_q[3:0]] <= tx_data;
         n_q <= n_q + 1;
      end
   end
endmodule
`default_nettype wire

// [sim/mdd_dispatch_monitor.sv]
// Purpose: port checker for the dispatch block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every dispatch instance
`timescale 1ns/1ps
`default_nettype none
module mdd_dispatch_monitor (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       req_valid,
   input wire logic       req_ready,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic       q_push_valid,
   input wire logic       cancel_valid,
   input wire logic       fetch_valid,
   input wire logic       q_ret_ready,
   input wire logic       shown_valid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence setup_s; psel && !penable; endsequence
   sequence stall_s; tx_valid && !tx_ready; endsequence
   apb_ready_a: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   apb_lone_a: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr outside access");
   tx_hold_a: assert property (stall_s |=> tx_valid && $stable(tx_data))
      else $error("byte dropped before taken");
   tx_busy_a: assert property (tx_valid |-> !req_ready)
      else $error("byte sent while idle");
   req_taken_a: assert property (req_valid && req_ready |=> !req_ready)
      else $error("ready stayed high after request");
   push_pulse_a: assert property ($rose(q_push_valid) |=> !q_push_valid)
      else $error("push longer than one cycle");
   cancel_pulse_a: assert property (cancel_valid |=> !cancel_valid)
      else $error("cancel longer than one cycle");
   fetch_pulse_a: assert property (fetch_valid |=> !fetch_valid)
      else $error("fetch longer than one cycle");
   ret_empty_a: assert property (q_ret_ready |-> !shown_valid)
      else $error("queue return while display busy");
endmodule
bind mdd_dispatch mdd_dispatch_monitor mon_i (.mclk(mclk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .req_valid(req_valid), .req_ready(req_ready), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_data(tx_data), .q_push_valid(q_push_valid),
   .cancel_valid(cancel_valid), .fetch_valid(fetch_valid),
   .q_ret_ready(q_ret_ready), .shown_valid(shown_valid));
`default_nettype wire

// [sim/test_message_destination_dispatch.sv]
// Purpose: directed bench for transmit, display time-out and commands
// Assumes: tick shortened to 20 cycles; tick phase free-running
// Notes:   time-out figures are checked with one tick of slack
`timescale 1ns/1ps
`default_nettype none
module test_message_destination_dispatch;
   logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, req_valid = 0, req_ready, tx_valid, tx_ready;
   logic q_push_valid, q_ret_valid = 0, q_ret_ready, cancel_valid;
   logic fetch_valid, shown_valid, slow = 1, err_q;
   logic [7:0] tx_data, cancel_msg, fetch_msg, shown_msg, cm, fm;
   logic [3:0][31:0] live_items = {96'h0, 32'h12AB34CD};
   mdd_pkg::mdd_rec_type   req_rec = '0, r;
   mdd_pkg::mdd_entry_type q_push_entry, q_ret_entry = '0, pe;
   int mismatches = 0, n_compared = 0, n, b, i;
   mdd_dispatch #(.TICK_CYCLES(20)) mdd_dispatch_i (.mclk(mclk),
      .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req_rec(req_rec),
      .req_ready(req_ready), .live_items(live_items), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .q_push_valid(q_push_valid),
      .q_push_entry(q_push_entry), .q_ret_valid(q_ret_valid),
      .q_ret_entry(q_ret_entry), .q_ret_ready(q_ret_ready),
      .cancel_valid(cancel_valid), .cancel_msg(cancel_msg),
      .fetch_valid(fetch_valid), .fetch_msg(fetch_msg),
      .shown_valid(shown_valid), .shown_msg(shown_msg));
   mdd_serial_rx mdd_serial_rx_i (.mclk(mclk), .slow(slow),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   always #5 mclk = !mclk;
   // latch pulse payloads mid-cycle, clear of the launching edge
   always @(negedge mclk)
   begin
      if (cancel_valid) cm <= cancel_msg;
      if (fetch_valid) fm <= fetch_msg;
      if (q_push_valid) pe <= q_push_entry;
   end
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic hang(input int k);
      if (k >= 2000)
      begin
         mismatches++;
         stop_test();
      end
   endtask
   // one APB transfer, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      int k;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1 && ++k < 2000);
      hang(k);
      rd = prdata;
      err_q = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   // hand a record over, wait for idle
   task automatic send(input mdd_pkg::mdd_rec_type x);
      int k;
      req_rec <= x;
      req_valid <= 1;
      do @(posedge mclk); while (req_ready !== 1'b1 && ++k < 2000);
      hang(k);
      req_valid <= 0;
      k = 0;
      do @(posedge mclk); while (req_ready !== 1'b1 && ++k < 2000);
      hang(k);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [14:0] cd);
      r = '0;
      r.dest = mdd_pkg::DEST_CMD;
      r.cmd = op;
      r.cdata = cd;
      send(r);
   endtask
   task automatic wait_off;
      for (n = 0; n < 2000 && shown_valid !== 1'b0; n++) @(posedge mclk);
      hang(n);
   endtask
   // compare received bytes, first leftmost
   task automatic check_rx(input int c, input logic [87:0] ex);
      check("rx count", mdd_serial_rx_i.n_q - b, c);
      for (i = 0; i < c; i++)
         check("rx byte", mdd_serial_rx_i.rx_q[(b + i) % 16],
               ex[8 * (c - 1 - i) +: 8]);
   endtask
   task automatic text(input logic [31:0] t, input int c);
      apb(1, mdd_pkg::ADDR_CTRL, 2);
      for (i = c - 1; i >= 0; i--) apb(1, mdd_pkg::ADDR_TXT, t[8 * i +: 8]);
      b = mdd_serial_rx_i.n_q;
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      reset_n <= 1;
      @(posedge mclk);
      apb(0, 8'h20, 0);
      check("unmapped err", err_q, 1);
      apb(0, mdd_pkg::ADDR_CFG, 0);
      check("cfg reset", rd, 32'h10D);
      text(32'h410D0780, 4);
      r = '0;
      r.dest = mdd_pkg::DEST_XMIT;
      send(r);
      check_rx(11, 88'h410D07_3132414233344344);
      text(0, 0);
      for (i = 0; i < 256; i++) apb(1, mdd_pkg::ADDR_TXT, 8'h42);
      apb(0, mdd_pkg::ADDR_TXT, 0);
      check("text cap", rd, 255);
      $display("test transmit done");
      text(0, 0);
      r = '0;
      r.msg = 8'h33;
      r.pri = 5;
      r.trng = mdd_pkg::TMO_MS;
      r.tval = 2;
      r.chain = 1;
      r.next = 8'h07;
      send(r);
      check("shown", {shown_valid, shown_msg}, 9'h133);
      wait_off();
      check("expiry time", n >= 19 && n <= 42, 1);
      check("cancel msg", cm, 8'h33);
      check("chain fetch", fm, 8'h07);
      r.msg = 8'h40;
      r.tval = 3;
      r.chain = 0;
      send(r);
      repeat (30) @(posedge mclk);
      r.msg = 8'h41;
      r.pri = 2;
      r.trng = mdd_pkg::TMO_OFF;
      send(r);
      check("bumped", {pe.msg, pe.remain > 0 && pe.remain < 3}, 9'h81);
      r.msg = 8'h42;
      r.pri = 9;
      send(r);
      repeat (100) @(posedge mclk);
      check("kept", {shown_valid, shown_msg}, 9'h141);
      cmd(mdd_pkg::CANCEL_ENTRY_CMD, 15'h41);
      check("cmd cancel", {shown_valid, cm}, 9'h041);
      q_ret_entry <= pe;
      q_ret_valid <= 1;
      n = 0;
      do @(posedge mclk); while (q_ret_ready !== 1'b1 && ++n < 2000);
      hang(n);
      q_ret_valid <= 0;
      @(posedge mclk);
      check("returned", shown_msg, 8'h40);
      wait_off();
      check("resumed", n <= 20 * pe.remain + 4, 1);
      $display("test time-out done");
      cmd(mdd_pkg::SHOW_ENTRY_CMD, 15'h55);
      check("cmd fetch", fm, 8'h55);
      cmd(mdd_pkg::SET_CONFIG_CMD, 15'h003);
      apb(0, mdd_pkg::ADDR_CFG, 0);
      check("cfg set", rd, 3);
      cmd(mdd_pkg::LOAD_DEFAULT_CONFIG_CMD, 0);
      apb(0, mdd_pkg::ADDR_CFG, 0);
      check("cfg default", rd, 32'h10D);
      b = mdd_serial_rx_i.n_q;
      cmd(mdd_pkg::DUMP_CONFIG_CMD, 0);
      check_rx(9, 72'h30303030303130440D);
      text(32'h5A, 1);
      r = '0;
      r.dest = mdd_pkg::DEST_SHOW_XMIT;
      r.msg = 8'h60;
      r.pri = 1;
      send(r);
      check_rx(1, 8'h5A);
      check("combined", {shown_valid, shown_msg}, 9'h160);
      $display("test commands done");
      stop_test();
   end
endmodule
`default_nettype wire
